// File: hdl/lsft_pkg.sv
// Shared constants and types for the scan frame timing link and device
package lsft_pkg;

  // Link commands carried in the three command bits of a frame
  typedef enum logic [2:0] {
    CMD_NONE       = 3'b000,
    CMD_CHIP_INDEX = 3'b001,
    CMD_WR_BCAST   = 3'b010,
    CMD_WR_ADDR    = 3'b011,
    CMD_VSYNC      = 3'b100,
    CMD_READ       = 3'b101
  } lsft_cmd_t;

  // Frame layout: start bit, command, address, 48-bit data, MSB first
  localparam int FRAME_BITS = 59;
  localparam int TX_BITS = 60;
  localparam int REPLY_BITS = 48;
  localparam int CMD_MSB = 58;
  localparam int CMD_LSB = 56;
  localparam int ADDR_MSB = 55;
  localparam int ADDR_LSB = 48;

  // Register indices
  localparam logic [7:0] REG_PRIMARY_A = 8'h00;
  localparam logic [7:0] REG_SCAN_TIMING = 8'h01;
  localparam logic [7:0] REG_BANK_TWO = 8'h02;
  localparam logic [7:0] REG_BANK_THREE = 8'h03;
  localparam logic [7:0] REG_ORDER_FIRST = 8'h06;
  localparam logic [7:0] REG_ORDER_LAST = 8'h0D;
  localparam logic [7:0] REG_OPEN_FIRST = 8'h0E;
  localparam logic [7:0] REG_SHORT_FIRST = 8'h12;
  localparam logic [7:0] REG_FLAG_LAST = 8'h15;

  // Scan timing config fields
  localparam int SEG_MSB = 9;
  localparam int SEG_LSB = 0;
  localparam int GAP_MSB = 40;
  localparam int GAP_LSB = 37;
  localparam int SHARE_MSB = 46;
  localparam int SHARE_LSB = 41;

  // Primary config fields
  localparam int LINES_MSB = 5;
  localparam int LINES_LSB = 0;
  localparam int SUBS_MSB = 11;
  localparam int SUBS_LSB = 6;
  localparam int MUL_MSB = 15;
  localparam int MUL_LSB = 12;
  localparam int EXTRA_MSB = 25;
  localparam int EXTRA_LSB = 16;
  localparam int EXTRA_GAP_BIT = 26;
  localparam int IDLE_MSB = 42;
  localparam int IDLE_LSB = 27;

  // Grayscale write: word index within the data field
  localparam int SRAM_IDX_MSB = 43;
  localparam int SRAM_IDX_LSB = 40;

  // Gap length per code step; code 0011 gives 120 grayscale clocks
  localparam logic [15:0] GAP_UNIT = 16'h001E;

  // Reset values
  localparam logic [47:0] PRIMARY_A_RST = 48'h0000_0000_1000;
  localparam logic [47:0] SCAN_TIMING_RST = 48'h0000_0000_0200;

  // Link clock made by the host: period in ns and half period in cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_PERIOD_NS = 120;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

endpackage

// File: hdl/lsft_link_if.sv
// Three-wire serial link between display controller and device
interface lsft_link_if;
  logic sclk;
  logic serial_in_pin;
  logic serial_out_pin;
  modport host(output sclk, output serial_in_pin, input serial_out_pin);
  modport dev(input sclk, input serial_in_pin, output serial_out_pin);
endinterface

// File: hdl/lsft_grayscale_clock_gen.sv
// Grayscale clock tick generator locked to a multiple of the link clock
module lsft_grayscale_clock_gen (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Reference edge and multiplier
  input wire logic i_ref_rise,
  input wire logic [3:0] i_mul,
  // Tick out
  output logic o_tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] period;
    logic [8:0] acc;
    logic tick;
  } lsft_gen_st_t;

  lsft_gen_st_t q, d;
  logic [8:0] sum;

  // Accumulator adds the multiplier each cycle, so ticks come at mul x ref
  always_comb begin
    d = q;
    sum = q.acc + {5'h00, i_mul};
    d.tick = 1'b0;
    if (i_ref_rise) begin
      d.period = q.cnt;
      d.cnt = 8'h01;
    end else if (q.cnt != 8'hFF) begin
      d.cnt = q.cnt + 8'h01;
    end
    if (q.period == 8'h00) begin
      d.acc = 9'h000;
    end else if (sum >= {1'b0, q.period}) begin
      d.acc = sum - {1'b0, q.period}; // RULE_19
      d.tick = 1'b1;
    end else begin
      d.acc = sum;
    end
    if (!i_rst_n) begin
      d = '0;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign o_tick = q.tick; // At most one tick per clock; fast mul saturates

endmodule

// File: hdl/lsft_device.sv
// Device end: link receiver, registers, frame swap and scan timing engine
// Operation
// RULE_01: Line gap counted in grayscale clocks, bits 40-37
// RULE_02: Gap code 0011 gives 120 clocks
// RULE_03: Segment blank share spread into every segment
// RULE_04: Blank share lengthens PWM or line gap
// RULE_05: Segment length from bits 9-0
// RULE_06: Sub-period blank share from bits 46-41
// RULE_07: Controller: index, configure, then sync each frame
// RULE_08: Frame sync shows last frame, buffers new
// RULE_09: Registers readable at any time in frame
// RULE_10: Chip index gives the device its address
// RULE_11: Configuration written only by broadcast write
// RULE_12: Primary registers update at sync, others immediately
// RULE_13: Grayscale enters memory by addressed write
// RULE_14: Registers six to thirteen hold scan order
// RULE_15: Indices fourteen to twenty-one read open/short flags
// RULE_16: All devices swap frame on same sync
// RULE_17: Controller orders channel data to match wiring
// RULE_18: Controller keeps serial clock running always
// RULE_19: Grayscale clock is serial clock times multiplier
// RULE_20: Leftover blank becomes idle, outputs off
module lsft_device
  import lsft_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // Serial link
  lsft_link_if.dev LINK,
  // Detection flags from the output stage
  input wire logic [47:0] I_OPEN_FLAGS,
  input wire logic [47:0] I_SHORT_FLAGS,
  // Scan outputs
  output logic [5:0] O_LINE,
  output logic O_PWM_ON,
  output logic O_LINE_GAP,
  output logic O_FRAME_IDLE,
  output logic [15:0] O_GS_WORD,
  output logic O_GRAYSCALE_CLOCK_TICK,
  output logic [7:0] O_CHIP_ADDR
);

  typedef enum logic [2:0] {
    PH_WAIT   = 3'b000,
    PH_PWM    = 3'b001,
    PH_GAP    = 3'b010,
    PH_SUBADJ = 3'b011,
    PH_IDLE   = 3'b100
  } lsft_phase_t;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic sin_s1;
    logic sin_s2;
    logic rx_busy;
    logic [5:0] rx_cnt;
    logic [58:0] rx_sh;
    logic tx_busy;
    logic [5:0] tx_cnt;
    logic [47:0] tx_sh;
    logic serial_out_pin;
    logic [7:0] chip_addr;
    logic [47:0] pa_stg;
    logic [47:0] st_stg;
    logic [47:0] pa;
    logic [47:0] st;
    logic [47:0] bank2;
    logic [47:0] bank3;
    logic [7:0][47:0] order;
    logic [1:0][15:0][15:0] sram;
    logic wr_bank;
    lsft_phase_t phase;
    logic [15:0] cnt;
    logic [5:0] line;
    logic [5:0] sub;
    logic [5:0] line_out;
    logic [15:0] gs_word;
    logic pwm_on;
    logic gap_on;
    logic idle_on;
  } lsft_dev_st_t;

  lsft_dev_st_t q, d;
  logic clk_rise;
  logic clk_fall;
  logic full;
  logic grayscale_clock_tick;
  logic sub_done;
  logic [58:0] frame;
  lsft_cmd_t cmd;
  logic [7:0] addr;
  logic [47:0] data;
  logic [47:0] rd_val;
  logic [15:0] pwm_len;
  logic [15:0] gap_len;
  logic [15:0] cnt_nx;

  // Scan order register index decode, used by write and read
  function automatic logic is_order(input logic [7:0] idx);
    return idx >= REG_ORDER_FIRST && idx <= REG_ORDER_LAST;
  endfunction

  // Physical line for a logical line: eight 6-bit entries per register
  function automatic logic [5:0] order_line(input logic [7:0][47:0] o,
                                            input logic [5:0] l);
    return o[l[5:3]][l[2:0] * 6 +: 6];
  endfunction

  // Edges of the sampled link clock
  assign clk_rise = q.sclk_s2 & ~q.sclk_s3;
  assign clk_fall = ~q.sclk_s2 & q.sclk_s3;
  assign frame = {q.rx_sh[57:0], q.sin_s2};
  assign cmd = lsft_cmd_t'(frame[CMD_MSB:CMD_LSB]);
  assign addr = frame[ADDR_MSB:ADDR_LSB];
  assign data = frame[47:0];
  assign full = clk_rise && q.rx_busy && q.rx_cnt == 6'(FRAME_BITS - 1);

  // Segment and gap lengths; the blank share goes to one or the other
  assign pwm_len = 16'(q.st[SEG_MSB:SEG_LSB]) // RULE_05
    + (q.pa[EXTRA_GAP_BIT] ? 16'h0000 : 16'(q.pa[EXTRA_MSB:EXTRA_LSB])); // RULE_03
  assign gap_len = GAP_UNIT * (16'(q.st[GAP_MSB:GAP_LSB]) + 16'h0001) // RULE_02
    + (q.pa[EXTRA_GAP_BIT] ? 16'(q.pa[EXTRA_MSB:EXTRA_LSB]) : 16'h0000); // RULE_04
  assign cnt_nx = q.cnt + 16'h0001;

  lsft_grayscale_clock_gen lsft_grayscale_clock_gen_inst (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_ref_rise(clk_rise),
    .i_mul(q.pa[MUL_MSB:MUL_LSB]),
    .o_tick(grayscale_clock_tick)
  );

  // Read mux; primary registers read back their last written value
  always_comb begin
    rd_val = 48'h0000_0000_0000;
    if (addr == REG_PRIMARY_A) begin
      rd_val = q.pa_stg;
    end else if (addr == REG_SCAN_TIMING) begin
      rd_val = q.st_stg;
    end else if (addr == REG_BANK_TWO) begin
      rd_val = q.bank2;
    end else if (addr == REG_BANK_THREE) begin
      rd_val = q.bank3;
    end else if (is_order(addr)) begin
      rd_val = q.order[3'(addr - REG_ORDER_FIRST)];
    end else if (addr >= REG_OPEN_FIRST && addr < REG_SHORT_FIRST) begin
      rd_val = I_OPEN_FLAGS; // RULE_15
    end else if (addr >= REG_SHORT_FIRST && addr <= REG_FLAG_LAST) begin
      rd_val = I_SHORT_FLAGS; // RULE_15
    end
  end

  // Next state
  always_comb begin
    d = q;
    sub_done = 1'b0;
    // Two-stage synchronisers plus an edge history stage
    d.sclk_s1 = LINK.sclk;
    d.sclk_s2 = q.sclk_s1;
    d.sclk_s3 = q.sclk_s2;
    d.sin_s1 = LINK.serial_in_pin;
    d.sin_s2 = q.sin_s1;
    // Receiver: a high bit on an idle line starts a frame
    if (clk_rise) begin
      if (!q.rx_busy) begin
        if (q.sin_s2 && !q.tx_busy) begin
          d.rx_busy = 1'b1;
          d.rx_cnt = 6'h00;
        end
      end else begin
        d.rx_sh = frame;
        d.rx_cnt = q.rx_cnt + 6'h01;
        if (full) begin
          d.rx_busy = 1'b0;
        end
      end
    end
    // Command execution, read allowed at any point of a frame
    if (full) begin
      unique case (cmd)
        CMD_CHIP_INDEX: d.chip_addr = data[7:0]; // RULE_10 RULE_07
        CMD_WR_BCAST: begin
          if (addr == REG_PRIMARY_A) begin
            d.pa_stg = data; // RULE_12
          end else if (addr == REG_SCAN_TIMING) begin
            d.st_stg = data; // RULE_12
          end else if (addr == REG_BANK_TWO) begin
            d.bank2 = data; // RULE_11
          end else if (addr == REG_BANK_THREE) begin
            d.bank3 = data; // RULE_11
          end else if (is_order(addr)) begin
            d.order[3'(addr - REG_ORDER_FIRST)] = data; // RULE_14
          end
        end
        CMD_WR_ADDR: begin
          if (addr == q.chip_addr) begin
            d.sram[q.wr_bank][data[SRAM_IDX_MSB:SRAM_IDX_LSB]] =
              data[15:0]; // RULE_13
          end
        end
        CMD_READ: begin
          d.tx_busy = 1'b1; // RULE_09
          d.tx_cnt = 6'h00;
          d.tx_sh = rd_val;
        end
        default: begin
        end
      endcase
    end
    // Reply shifts out on falling link clock edges
    if (clk_fall && q.tx_busy) begin
      if (q.tx_cnt == 6'(REPLY_BITS)) begin
        d.tx_busy = 1'b0;
        d.serial_out_pin = 1'b0;
      end else begin
        d.serial_out_pin = q.tx_sh[47];
        d.tx_sh = {q.tx_sh[46:0], 1'b0};
        d.tx_cnt = q.tx_cnt + 6'h01;
      end
    end
    // Scan timing engine stepped by grayscale clock ticks
    if (grayscale_clock_tick) begin
      unique case (q.phase)
        PH_WAIT: begin
        end
        PH_PWM: begin
          if (cnt_nx >= pwm_len) begin
            d.phase = PH_GAP;
            d.cnt = 16'h0000;
          end else begin
            d.cnt = cnt_nx;
          end
        end
        PH_GAP: begin
          if (cnt_nx >= gap_len) begin // RULE_01
            d.cnt = 16'h0000;
            if (q.line == q.pa[LINES_MSB:LINES_LSB]) begin
              d.line = 6'h00;
              if (q.st[SHARE_MSB:SHARE_LSB] != 6'h00) begin
                d.phase = PH_SUBADJ;
              end else begin
                sub_done = 1'b1;
              end
            end else begin
              d.line = q.line + 6'h01;
              d.phase = PH_PWM;
            end
          end else begin
            d.cnt = cnt_nx;
          end
        end
        PH_SUBADJ: begin
          if (cnt_nx >= 16'(q.st[SHARE_MSB:SHARE_LSB])) begin // RULE_06
            d.cnt = 16'h0000;
            sub_done = 1'b1;
          end else begin
            d.cnt = cnt_nx;
          end
        end
        PH_IDLE: begin
          if (cnt_nx >= 16'(q.pa[IDLE_MSB:IDLE_LSB])) begin // RULE_20
            d.phase = PH_WAIT;
            d.cnt = 16'h0000;
          end else begin
            d.cnt = cnt_nx;
          end
        end
        default: d.phase = PH_WAIT;
      endcase
    end
    if (sub_done) begin
      if (q.sub == q.pa[SUBS_MSB:SUBS_LSB]) begin
        d.sub = 6'h00;
        d.phase = PH_IDLE;
      end else begin
        d.sub = q.sub + 6'h01;
        d.phase = PH_PWM;
      end
    end
    // Frame sync: every device swaps whatever its address
    if (full && cmd == CMD_VSYNC) begin
      d.pa = q.pa_stg; // RULE_12
      d.st = q.st_stg; // RULE_12
      d.wr_bank = ~q.wr_bank; // RULE_08 RULE_16
      d.phase = PH_PWM;
      d.cnt = 16'h0000;
      d.line = 6'h00;
      d.sub = 6'h00;
    end
    // Registered outputs; display reads the bank not being written
    d.line_out = order_line(q.order, q.line); // RULE_14
    d.gs_word = q.sram[~q.wr_bank][q.line_out[3:0]]; // RULE_08
    d.pwm_on = q.phase == PH_PWM && q.cnt < q.gs_word;
    d.gap_on = q.phase == PH_GAP;
    d.idle_on = q.phase == PH_IDLE; // RULE_20
    if (!I_RST_N) begin
      d = '0;
      d.pa = PRIMARY_A_RST;
      d.pa_stg = PRIMARY_A_RST;
      d.st = SCAN_TIMING_RST;
      d.st_stg = SCAN_TIMING_RST;
    end
  end

  // State register
  always_ff @(posedge I_MCLK) begin
    q <= d;
  end

  assign LINK.serial_out_pin = q.serial_out_pin;
  assign O_LINE = q.line_out;
  assign O_PWM_ON = q.pwm_on;
  assign O_LINE_GAP = q.gap_on;
  assign O_FRAME_IDLE = q.idle_on;
  assign O_GS_WORD = q.gs_word;
  assign O_GRAYSCALE_CLOCK_TICK = grayscale_clock_tick;
  assign O_CHIP_ADDR = q.chip_addr;

endmodule

// File: hdl/lsft_host.sv
// Controller end: link clock divider, frame sender and reply receiver
module lsft_host
  import lsft_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // Serial link
  lsft_link_if.host LINK,
  // Command port
  input wire logic I_CMD_VALID,
  input wire lsft_cmd_t I_CMD,
  input wire logic [7:0] I_ADDR,
  input wire logic [47:0] I_DATA,
  output logic O_CMD_READY,
  // Read answer
  output logic O_RD_VALID,
  output logic [47:0] O_RD_DATA
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_RECV = 2'b10
  } lsft_host_state_t;

  typedef struct packed {
    lsft_host_state_t state;
    logic [3:0] div;
    logic sclk;
    logic serial_in_pin;
    logic [59:0] sh;
    logic [6:0] bit_cnt;
    logic is_read;
    logic [47:0] rx;
    logic serial_out_pin_s1;
    logic serial_out_pin_s2;
    logic rd_valid;
    logic [47:0] rd_data;
  } lsft_host_st_t;

  lsft_host_st_t q, d;
  logic half;
  logic fall;
  logic rise;

  assign half = q.div == 4'(SCLK_HALF_CYC - 1);
  assign fall = half && q.sclk;
  assign rise = half && !q.sclk;

  // Next state
  always_comb begin
    d = q;
    d.serial_out_pin_s1 = LINK.serial_out_pin;
    d.serial_out_pin_s2 = q.serial_out_pin_s1;
    d.rd_valid = 1'b0;
    // Link clock never stops: the device builds its timing from it
    if (half) begin
      d.div = 4'h0;
      d.sclk = ~q.sclk; // RULE_18
    end else begin
      d.div = q.div + 4'h1;
    end
    unique case (q.state)
      H_IDLE: begin
        if (I_CMD_VALID) begin
          d.sh = {1'b1, I_CMD, I_ADDR, I_DATA};
          d.is_read = I_CMD == CMD_READ;
          d.bit_cnt = 7'h00;
          d.state = H_SEND;
        end
      end
      H_SEND: begin
        // Data changes on falling edges, device samples on rising
        if (fall) begin
          if (q.bit_cnt == 7'(TX_BITS)) begin
            d.serial_in_pin = 1'b0;
            d.bit_cnt = 7'h00;
            d.state = q.is_read ? H_RECV : H_IDLE;
          end else begin
            d.serial_in_pin = q.sh[59];
            d.sh = {q.sh[58:0], 1'b0};
            d.bit_cnt = q.bit_cnt + 7'h01;
          end
        end
      end
      H_RECV: begin
        if (rise) begin
          d.rx = {q.rx[46:0], q.serial_out_pin_s2};
          d.bit_cnt = q.bit_cnt + 7'h01;
          if (q.bit_cnt == 7'(REPLY_BITS - 1)) begin
            d.rd_data = {q.rx[46:0], q.serial_out_pin_s2};
            d.rd_valid = 1'b1;
            d.state = H_IDLE;
          end
        end
      end
      default: d.state = H_IDLE;
    endcase
    if (!I_RST_N) begin
      d = '0;
    end
  end

  // State register
  always_ff @(posedge I_MCLK) begin
    q <= d;
  end

  assign O_CMD_READY = q.state == H_IDLE;
  assign O_RD_VALID = q.rd_valid;
  assign O_RD_DATA = q.rd_data;
  assign LINK.sclk = q.sclk;
  assign LINK.serial_in_pin = q.serial_in_pin;

endmodule

// File: tb/lsft_properties.sv
// Properties watching the link wires and the device scan outputs
module lsft_properties (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link wires
  input wire logic i_sclk,
  input wire logic i_sin,
  input wire logic i_serial_out_pin,
  // Scan and reply outputs
  input wire logic i_line_gap,
  input wire logic i_pwm_on,
  input wire logic i_frame_idle,
  input wire logic i_grayscale_clock_tick,
  input wire logic [5:0] i_line,
  input wire logic [15:0] i_gs_word,
  input wire logic i_rd_valid
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // Link clock never pauses; grayscale timing depends on it
  a_sclk_half_period: assert property (
    $changed(i_sclk) |=> $stable(i_sclk)[*8] ##1 $stable(i_sclk)[*3]
    ##1 $changed(i_sclk)) else $error("link clock half period wrong");
  // Data wires move only while the link clock is low
  a_sin_on_low: assert property (
    $changed(i_sin) |-> !i_sclk) else $error("sin moved with clock high");
  a_serial_out_pin_on_low: assert property (
    $changed(i_serial_out_pin) |-> !i_sclk) else $error("serial_out_pin moved with clock high");
  // Gap entry lands on a grayscale tick, two stages later
  a_gap_on_tick: assert property (
    $rose(i_line_gap) |-> $past(i_grayscale_clock_tick, 2))
    else $error("line gap began off a tick");
  // Outputs stay dark in frame idle and in the line gap
  a_idle_dark: assert property (
    i_frame_idle |-> !i_pwm_on && !i_line_gap)
    else $error("outputs lit in frame idle");
  a_gap_dark: assert property (
    i_line_gap |-> !i_pwm_on) else $error("outputs lit in line gap");
  // Line and shown word hold while the gap runs
  a_line_steady: assert property (
    i_line_gap && $past(i_line_gap) |-> $stable(i_line))
    else $error("scan line moved inside gap");
  a_gs_steady: assert property (
    i_line_gap && $past(i_line_gap) |-> $stable(i_gs_word))
    else $error("shown word moved inside gap");
  a_rd_single: assert property (
    i_rd_valid |=> !i_rd_valid) else $error("read valid held too long");

  // Main scenarios reached
  cover property ($rose(i_line_gap));
  cover property ($rose(i_frame_idle));
  cover property (i_rd_valid);
  cover property ($changed(i_serial_out_pin));
endmodule

// File: tb/led_scan_frame_timing_config_bench.sv
// Bench joining host and device over the link, checking frames and reads
module led_scan_frame_timing_config_bench
  import lsft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic cmd_valid = 1'b0;
  lsft_cmd_t cmd = CMD_NONE;
  logic [7:0] addr = 8'h00;
  logic [47:0] data = 48'h0000_0000_0000;
  logic [47:0] open_f = 48'h0000_0000_0000;
  logic [47:0] short_f = 48'h0000_0000_0000;
  logic cmd_ready, rd_valid, line_gap, pwm_on, frame_idle, grayscale_clock_tick;
  logic [47:0] rd_data;
  logic [5:0] line;
  logic [15:0] gs_word;
  logic [7:0] chip_addr;
  logic gap_prev = 1'b0;
  logic [15:0] gap_n = 16'h0000;
  int n_mismatch = 0;
  int checked = 0;
  logic [47:0] rd_q[$];
  logic [15:0] gap_q[$];
  logic [15:0] gs_q[$];
  logic idle_prev = 1'b0;
  logic pwm_prev = 1'b0;
  logic [15:0] blank_n = 16'h0000;
  logic [15:0] cyc_n = 16'h0000;
  logic [15:0] tick_sp = 16'h0000;
  logic [15:0] bl_q[$];
  logic [15:0] sp_q[$];

  lsft_link_if lsft_link_if_inst ();
  lsft_host lsft_host_inst (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
    .LINK(lsft_link_if_inst), .I_CMD_VALID(cmd_valid), .I_CMD(cmd),
    .I_ADDR(addr), .I_DATA(data), .O_CMD_READY(cmd_ready),
    .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data));
  lsft_device lsft_device_inst (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
    .LINK(lsft_link_if_inst), .I_OPEN_FLAGS(open_f),
    .I_SHORT_FLAGS(short_f), .O_LINE(line), .O_PWM_ON(pwm_on),
    .O_LINE_GAP(line_gap), .O_FRAME_IDLE(frame_idle),
    .O_GS_WORD(gs_word), .O_GRAYSCALE_CLOCK_TICK(grayscale_clock_tick),
    .O_CHIP_ADDR(chip_addr));
  lsft_properties lsft_properties_inst (.i_mclk(I_MCLK),
    .i_rst_n(I_RST_N), .i_sclk(lsft_link_if_inst.sclk),
    .i_sin(lsft_link_if_inst.serial_in_pin), .i_serial_out_pin(lsft_link_if_inst.serial_out_pin),
    .i_line_gap(line_gap), .i_pwm_on(pwm_on),
    .i_frame_idle(frame_idle), .i_grayscale_clock_tick(grayscale_clock_tick), .i_line(line),
    .i_gs_word(gs_word), .i_rd_valid(rd_valid));

  // 200 MHz system clock
  initial begin
    forever #2.5 I_MCLK = ~I_MCLK;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Request held until the edge that sees ready high
  task automatic send(input lsft_cmd_t c, input logic [7:0] a,
                      input logic [47:0] d);
    @(negedge I_MCLK);
    cmd = c;
    addr = a;
    data = d;
    cmd_valid = 1'b1;
    do @(posedge I_MCLK); while (cmd_ready !== 1'b1);
    @(negedge I_MCLK);
    cmd_valid = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [47:0] e);
    rd_q.push_back(e);
    send(CMD_READ, a, 48'h0000_0000_0000);
  endtask

  // Result watcher: read replies, gap length and shown word per frame
  always @(posedge I_MCLK) begin
    gap_prev <= line_gap;
    idle_prev <= frame_idle;
    pwm_prev <= pwm_on;
    if (rd_valid === 1'b1) begin
      check(rd_data, rd_q.pop_front());
    end
    if (line_gap === 1'b1 && gap_prev !== 1'b1) begin
      gap_n <= 16'h0000;
      check(48'(gs_word), 48'(gs_q.pop_front()));
      // Last of 16 PWM counts still lit only for a word of 16 or more
      check(48'(pwm_prev), 48'(gs_word >= 16'h0010));
    end else if (line_gap === 1'b1 && grayscale_clock_tick === 1'b1) begin
      gap_n <= gap_n + 16'h0001;
    end
    if (line_gap !== 1'b1 && gap_prev === 1'b1) begin
      check(48'(gap_n), 48'(gap_q.pop_front()));
      check(48'(tick_sp), 48'(sp_q.pop_front()));
    end
    // Tick spacing in system clocks, sets the grayscale rate
    if (grayscale_clock_tick === 1'b1) begin
      tick_sp <= cyc_n;
      cyc_n <= 16'h0001;
    end else begin
      cyc_n <= cyc_n + 16'h0001;
    end
    // Sub-period share counted from gap end; idle itself is one tick
    if (frame_idle === 1'b1 && idle_prev !== 1'b1) begin
      blank_n <= 16'h0000;
      check(48'(blank_n), 48'(bl_q.pop_front()));
    end else if (frame_idle !== 1'b1 && idle_prev === 1'b1) begin
      check(48'(blank_n), 48'h0000_0000_0001);
    end else if (line_gap === 1'b1) begin
      blank_n <= 16'h0000;
    end else if (grayscale_clock_tick === 1'b1) begin
      blank_n <= blank_n + 16'h0001;
    end
  end

  // Watchdog sized well past the expected run
  initial begin
    repeat (90000) @(posedge I_MCLK);
    n_mismatch++;
    conclude();
  end

  // Bring-up, two frames, then the register table
  initial begin
    logic [7:0] ca;
    logic [15:0] g1, g2;
    logic [47:0] st2, r6, r13;
    void'($urandom(32'h573b_86ac));
    ca = 8'($urandom_range(254, 1));
    g1 = 16'($urandom());
    g2 = 16'($urandom());
    st2 = {1'b0, 6'($urandom()), 31'h0000_0000, 10'h010};
    r6 = 48'({$urandom(), $urandom()});
    r13 = 48'({$urandom(), $urandom()});
    repeat (4) @(posedge I_MCLK);
    @(negedge I_MCLK);
    I_RST_N = 1'b1;
    open_f = 48'({$urandom(), $urandom()});
    short_f = 48'({$urandom(), $urandom()});
    send(CMD_CHIP_INDEX, 8'h00, 48'(ca));
    // One line, one sub-period, multiplier 1, idle 1 tick
    send(CMD_WR_BCAST, REG_PRIMARY_A, 48'h0000_0800_1000);
    send(CMD_WR_BCAST, REG_SCAN_TIMING, 48'h0060_0000_0010);
    send(CMD_WR_ADDR, ca, 48'(g1));
    gs_q.push_back(g1);
    gap_q.push_back(16'h0078);
    bl_q.push_back(16'h0000);
    sp_q.push_back(16'(2 * SCLK_HALF_CYC));
    send(CMD_VSYNC, 8'h00, 48'h0000_0000_0000);
    // Staged during frame one; gap stays 120 until next sync
    send(CMD_WR_BCAST, REG_SCAN_TIMING, st2);
    // Share 5 to the gap, multiplier 2
    send(CMD_WR_BCAST, REG_PRIMARY_A, 48'h0000_0C05_2000);
    rd(REG_SCAN_TIMING, st2);
    send(CMD_WR_ADDR, ca, 48'(g2));
    send(CMD_WR_ADDR, 8'(ca + 8'h01), 48'(~g2));
    gs_q.push_back(g2);
    gap_q.push_back(16'h0023);
    bl_q.push_back(16'(st2[SHARE_MSB:SHARE_LSB]));
    sp_q.push_back(16'(SCLK_HALF_CYC));
    while (gap_q.size() > 1) @(posedge I_MCLK);
    send(CMD_VSYNC, 8'h00, 48'h0000_0000_0000);
    check(48'(chip_addr), 48'(ca));
    while (gap_q.size() > 0) @(posedge I_MCLK);
    // Scan order, read-only flags, unmapped index
    send(CMD_WR_BCAST, REG_ORDER_FIRST, r6);
    send(CMD_WR_BCAST, REG_ORDER_LAST, r13);
    // Line 0 now maps through the first order entry
    check(48'(line), 48'(r6[5:0]));
    send(CMD_WR_BCAST, REG_OPEN_FIRST, ~open_f);
    rd(REG_ORDER_FIRST, r6);
    rd(REG_ORDER_LAST, r13);
    rd(REG_OPEN_FIRST, open_f);
    rd(8'h11, open_f);
    rd(REG_SHORT_FIRST, short_f);
    rd(REG_FLAG_LAST, short_f);
    rd(8'h20, 48'h0000_0000_0000);
    rd(REG_PRIMARY_A, 48'h0000_0C05_2000);
    while (rd_q.size() > 0) @(posedge I_MCLK);
    check(48'(gs_q.size() + bl_q.size()), 48'h0000_0000_0000);
    conclude();
  end
endmodule
